// ---- design/aacsr_regs.sv ----
`timescale 1ns/10ps
`default_nettype none
////////////////////////////////////////////////////////////////////////
// Overview of operation
// - Detect rate and ratio, report in status
// - Rate codes per table, 001/010 unused
// - Ratio codes 64x to 512x, 110/111 unused
// - 64x only valid at 44.1/48 kHz
// - Identification register is read-only
// - Error flags sticky until software clears them
// - Error flag positions bit 7 down to 1
// - Flag master-clock count change per frame
// - Flag bit-clock count change per frame
// - Flag frame-clock change and frame slip
// - Bit 7 enables dc-blocking filter
// - Bit 5 picks hard or soft unmute
// - Two low bits select de-emphasis
// - Nine serial formats, 24-bit I2S default
// - Shutdown bit holds outputs in hard mute
// - Bit 7 enables half-level output ramp
// - Bit 3 enables ternary modulation
// - Bit 1 makes fault pin an output
// - Soft ramp defaults to 512 steps
module aacsr_regs
  import aacsr_pkg::*;
#(
  parameter logic [6:0] BUS_ADDR = BUS_ADDR_DEFAULT,
  // Arbitrary identification value.
  parameter logic [7:0] FW_IDENT = 8'h5A,
  parameter int RAMP_STEPS = RAMP_STEPS_DEFAULT
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic resetn,
  // Serial control bus.
  input wire logic scl,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // Serial audio clocks.
  input wire logic mclk,
  input wire logic sclk,
  input wire logic lrclk,
  // Events from the output stage.
  input wire logic clip_event,
  input wire logic prot_fault,
  // Fault pin.
  input wire logic fault_n_in,
  output logic fault_n_out,
  output logic fault_n_oe,
  // Settings and state for the audio path.
  output logic dc_block_en,
  output logic hard_unmute,
  output logic [1:0] deemph_sel,
  output logic [3:0] serial_fmt,
  output logic shutdown,
  output logic midz_ramp_en,
  output logic ternary_en,
  output logic audio_mute,
  output logic [11:0] unmute_level
);
  typedef enum logic [3:0] {
    ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_SUB, ST_SUB_ACK,
    ST_WR, ST_WR_ACK, ST_RD, ST_RD_ACK
  } aacsr_state_t;

  localparam logic [11:0] STEPS = 12'(RAMP_STEPS);
  localparam logic [11:0] STEP_LAST = 12'(RAMP_STEP_CYC - 1);

  logic rst_a_reg, rst_n;
  logic [6:0] raw, lvl, rise, fall;
  aacsr_state_t state_reg;
  logic [3:0] bit_cnt_reg;
  logic [7:0] shift_reg, sub_reg, tx_reg, rd_data;
  logic rw_reg, sda_oe_reg, sda_out_reg;
  logic wr_stb_reg;
  logic [7:0] wr_idx_reg, wr_dat_reg;
  logic [7:0] clk_stat_reg, err_reg, sc1_reg, fmt_reg, sc2_reg;
  logic [9:0] mclk_cnt_reg, mclk_meas_reg;
  logic [7:0] sclk_cnt_reg, sclk_meas_reg;
  logic [11:0] per_cnt_reg, per_meas_reg, fr_cnt_reg;
  logic [1:0] frames_reg;
  logic [2:0] rate_new, ratio_new;
  logic ratio_ok, lr_edge, fr_valid, fr_full;
  logic ev_mclk, ev_sclk, ev_lr, ev_pll, ev_slip, ev_clk;
  logic [7:0] ev_vec;
  logic clk_err_live_reg, audio_mute_reg, fault_oe_reg;
  logic [11:0] level_reg, step_cnt_reg;

  // Distance between two counts beyond a tolerance.
  function automatic logic far(input logic [11:0] a, input logic [11:0] b,
                               input logic [11:0] tol);
    far = (a > b) ? (a - b > tol) : (b - a > tol);
  endfunction

  // Period length in system clocks to sample-rate code.
  function automatic logic [2:0] rate_code(input logic [11:0] p);
    if (p < 12'(THR_48K_CYC)) rate_code = FS_48K;
    else if (p < 12'(THR_32K_CYC)) rate_code = FS_32K;
    else if (p < 12'(THR_24K_CYC)) rate_code = FS_24K;
    else if (p < 12'(THR_16K_CYC)) rate_code = FS_16K;
    else if (p < 12'(THR_12K_CYC)) rate_code = FS_12K;
    else rate_code = FS_8K;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Reset release and input synchronisers.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rst_a_reg <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_a_reg <= 1'b1;
      rst_n <= rst_a_reg;
    end
  end

  assign raw = {fault_n_in, prot_fault, lrclk, sclk, mclk, sda_in, scl};

  aacsr_sync #(.W(7), .INIT(SYNC_INIT)) u_sync (
    .clk(clk),
    .rst_n(rst_n),
    .async_in(raw),
    .lvl(lvl),
    .rise(rise),
    .fall(fall)
  );

  ////////////////////////////////////////////////////////////////////////
  // Serial control slave: address, subaddress, auto-increment data.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= ST_IDLE;
      bit_cnt_reg <= 4'h0;
      shift_reg <= 8'h00;
      sub_reg <= 8'h00;
      tx_reg <= 8'h00;
      rw_reg <= 1'b0;
      sda_oe_reg <= 1'b0;
      wr_stb_reg <= 1'b0;
      wr_idx_reg <= 8'h00;
      wr_dat_reg <= 8'h00;
    end else begin
      wr_stb_reg <= 1'b0;
      if (fall[1] && lvl[0]) begin
        // A start, repeated or not, resynchronises the byte framing.
        state_reg <= ST_ADDR;
        bit_cnt_reg <= 4'h0;
        sda_oe_reg <= 1'b0;
      end else if (rise[1] && lvl[0]) begin
        state_reg <= ST_IDLE;
        sda_oe_reg <= 1'b0;
      end else if (rise[0]) begin
        if (state_reg == ST_ADDR || state_reg == ST_SUB ||
            state_reg == ST_WR || state_reg == ST_RD_ACK) begin
          shift_reg <= {shift_reg[6:0], lvl[1]};
          bit_cnt_reg <= bit_cnt_reg + 4'h1;
        end
      end else if (fall[0]) begin
        case (state_reg)
          ST_ADDR: begin
            if (bit_cnt_reg == 4'h8) begin
              bit_cnt_reg <= 4'h0;
              rw_reg <= shift_reg[0];
              sda_oe_reg <= (shift_reg[7:1] == BUS_ADDR);
              state_reg <= (shift_reg[7:1] == BUS_ADDR) ? ST_ADDR_ACK
                                                         : ST_IDLE;
            end
          end
          ST_ADDR_ACK, ST_RD_ACK: begin
            // Master acknowledge (low) asks for the next byte.
            if (rw_reg && (state_reg == ST_ADDR_ACK || !shift_reg[0])) begin
              state_reg <= ST_RD;
              tx_reg <= {rd_data[6:0], 1'b0};
              sda_oe_reg <= !rd_data[7];
              bit_cnt_reg <= 4'h1;
            end else begin
              state_reg <= rw_reg ? ST_IDLE : ST_SUB;
              sda_oe_reg <= 1'b0;
              bit_cnt_reg <= 4'h0;
            end
          end
          ST_SUB: begin
            if (bit_cnt_reg == 4'h8) begin
              sub_reg <= shift_reg;
              sda_oe_reg <= 1'b1;
              state_reg <= ST_SUB_ACK;
            end
          end
          ST_WR: begin
            if (bit_cnt_reg == 4'h8) begin
              wr_stb_reg <= 1'b1;
              wr_idx_reg <= sub_reg;
              wr_dat_reg <= shift_reg;
              sda_oe_reg <= 1'b1;
              state_reg <= ST_WR_ACK;
            end
          end
          ST_SUB_ACK, ST_WR_ACK: begin
            if (state_reg == ST_WR_ACK) begin
              sub_reg <= sub_reg + 8'h01;
            end
            sda_oe_reg <= 1'b0;
            bit_cnt_reg <= 4'h0;
            state_reg <= ST_WR;
          end
          ST_RD: begin
            if (bit_cnt_reg == 4'h8) begin
              sub_reg <= sub_reg + 8'h01;
              sda_oe_reg <= 1'b0;
              bit_cnt_reg <= 4'h0;
              state_reg <= ST_RD_ACK;
            end else begin
              sda_oe_reg <= !tx_reg[7];
              tx_reg <= {tx_reg[6:0], 1'b0};
              bit_cnt_reg <= bit_cnt_reg + 4'h1;
            end
          end
          default: state_reg <= ST_IDLE;
        endcase
      end
    end
  end

  // Read mux; unmapped subaddresses read as zero.
  always_comb begin
    case (sub_reg)
      REG_CLOCK_DETECT_STATUS: rd_data = clk_stat_reg;
      REG_FIRMWARE_IDENT: rd_data = FW_IDENT;
      REG_STICKY_ERROR_FLAGS: rd_data = err_reg;
      REG_SYSTEM_CONTROL_FIRST: rd_data = sc1_reg;
      REG_SERIAL_AUDIO_FORMAT: rd_data = fmt_reg;
      REG_SYSTEM_CONTROL_SECOND: rd_data = sc2_reg;
      default: rd_data = 8'h00;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Writable settings. Reserved bits are masked so they read as zero.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sc1_reg <= RST_SYSTEM_CONTROL_FIRST;
      fmt_reg <= RST_SERIAL_AUDIO_FORMAT;
      sc2_reg <= RST_SYSTEM_CONTROL_SECOND;
    end else if (wr_stb_reg) begin
      if (wr_idx_reg == REG_SYSTEM_CONTROL_FIRST) begin
        sc1_reg <= wr_dat_reg & SC1_USED_MASK;
      end
      // Reserved format codes are refused; the old format stays.
      if (wr_idx_reg == REG_SERIAL_AUDIO_FORMAT &&
          wr_dat_reg[7:4] == 4'h0 && wr_dat_reg[3:0] <= FMT_LAST_CODE) begin
        fmt_reg <= wr_dat_reg;
      end
      if (wr_idx_reg == REG_SYSTEM_CONTROL_SECOND) begin
        sc2_reg <= wr_dat_reg & SC2_USED_MASK;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Per-frame clock measurement, framed by frame-clock rising edges.
  assign lr_edge = rise[4];
  assign fr_valid = frames_reg != 2'd0;
  assign fr_full = frames_reg == 2'd2;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mclk_cnt_reg <= 10'h000;
      sclk_cnt_reg <= 8'h00;
      per_cnt_reg <= 12'h000;
      mclk_meas_reg <= 10'h000;
      sclk_meas_reg <= 8'h00;
      per_meas_reg <= 12'h000;
      frames_reg <= 2'd0;
    end else if (lr_edge) begin
      mclk_meas_reg <= mclk_cnt_reg;
      sclk_meas_reg <= sclk_cnt_reg;
      per_meas_reg <= per_cnt_reg;
      mclk_cnt_reg <= 10'h000;
      sclk_cnt_reg <= 8'h00;
      per_cnt_reg <= 12'h000;
      frames_reg <= fr_full ? 2'd2 : frames_reg + 2'd1;
    end else if (per_cnt_reg == PERIOD_MAX_CYC) begin
      // A stopped frame clock restarts measurement from scratch.
      frames_reg <= 2'd0;
    end else begin
      mclk_cnt_reg <= mclk_cnt_reg + {9'h000, rise[2] && !(&mclk_cnt_reg)};
      sclk_cnt_reg <= sclk_cnt_reg + {7'h00, rise[3] && !(&sclk_cnt_reg)};
      per_cnt_reg <= per_cnt_reg + 12'h001;
    end
  end

  // Master-clock count to ratio code; off-grid counts are not accepted.
  always_comb begin
    ratio_ok = 1'b1;
    ratio_new = MR_256;
    if (!far({2'b00, mclk_cnt_reg}, 12'd64, MEAS_TOL)) ratio_new = MR_64;
    else if (!far({2'b00, mclk_cnt_reg}, 12'd128, MEAS_TOL))
      ratio_new = MR_128;
    else if (!far({2'b00, mclk_cnt_reg}, 12'd192, MEAS_TOL))
      ratio_new = MR_192;
    else if (!far({2'b00, mclk_cnt_reg}, 12'd256, MEAS_TOL))
      ratio_new = MR_256;
    else if (!far({2'b00, mclk_cnt_reg}, 12'd384, MEAS_TOL))
      ratio_new = MR_384;
    else if (!far({2'b00, mclk_cnt_reg}, 12'd512, MEAS_TOL))
      ratio_new = MR_512;
    else ratio_ok = 1'b0;
    rate_new = rate_code(per_cnt_reg);
    if (ratio_new == MR_64 && rate_new != FS_48K) ratio_ok = 1'b0;
  end

  // Clock error events; the frame sync freewheels to expose slips.
  assign ev_mclk = lr_edge && fr_full && far({2'b00, mclk_cnt_reg},
                   {2'b00, mclk_meas_reg}, MEAS_TOL);
  assign ev_sclk = lr_edge && fr_full && far({4'h0, sclk_cnt_reg},
                   {4'h0, sclk_meas_reg}, MEAS_TOL);
  assign ev_lr = (lr_edge && fr_full &&
                  far(per_cnt_reg, per_meas_reg, MEAS_TOL)) ||
                 per_cnt_reg == PERIOD_MAX_CYC - 12'h001;
  assign ev_slip = lr_edge && fr_full && !ev_lr && fr_cnt_reg > SLIP_TOL &&
                   fr_cnt_reg + SLIP_TOL < per_meas_reg;
  assign ev_pll = lr_edge && fr_valid && !ratio_ok;
  assign ev_clk = ev_mclk || ev_sclk || ev_lr || ev_slip || ev_pll;
  assign ev_vec = {ev_mclk, ev_pll, ev_sclk, ev_lr, ev_slip, clip_event,
                   lvl[5] || (!lvl[6] && !sc2_reg[SC2_FAULT_OUT_BIT]),
                   1'b0};

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fr_cnt_reg <= 12'h000;
    end else if (lr_edge && (!fr_full || ev_slip || ev_lr)) begin
      fr_cnt_reg <= 12'h000;
    end else if (fr_cnt_reg == per_meas_reg) begin
      fr_cnt_reg <= 12'h000;
    end else begin
      fr_cnt_reg <= fr_cnt_reg + 12'h001;
    end
  end

  // Detected status updates only on an accepted frame, from the second frame edge on.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      clk_stat_reg <= RST_CLOCK_DETECT_STATUS;
    end else if (lr_edge && fr_valid && ratio_ok) begin
      clk_stat_reg <= {rate_new, ratio_new, 2'b00};
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Sticky flags: only a write of zero clears, and a new event wins.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      err_reg <= RST_STICKY_ERROR_FLAGS;
    end else if (wr_stb_reg && wr_idx_reg == REG_STICKY_ERROR_FLAGS) begin
      err_reg <= ((err_reg & wr_dat_reg) | ev_vec) & ERR_USED_MASK;
    end else begin
      err_reg <= (err_reg | ev_vec) & ERR_USED_MASK;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Live clock error: held until one clean full frame is seen.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      clk_err_live_reg <= 1'b0;
      audio_mute_reg <= 1'b1;
    end else begin
      if (ev_clk) begin
        clk_err_live_reg <= 1'b1;
      end else if (lr_edge && fr_full) begin
        clk_err_live_reg <= 1'b0;
      end
      audio_mute_reg <= clk_err_live_reg || sc2_reg[SC2_SHUTDOWN_BIT];
    end
  end

  // Unmute level: zero while muted, then a step ramp or one jump.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      level_reg <= 12'h000;
      step_cnt_reg <= 12'h000;
    end else if (audio_mute_reg) begin
      level_reg <= 12'h000;
      step_cnt_reg <= 12'h000;
    end else if (level_reg != STEPS) begin
      if (sc1_reg[SC1_HARD_UNMUTE_BIT]) begin
        level_reg <= STEPS;
      end else if (step_cnt_reg == STEP_LAST) begin
        step_cnt_reg <= 12'h000;
        level_reg <= level_reg + 12'h001;
      end else begin
        step_cnt_reg <= step_cnt_reg + 12'h001;
      end
    end
  end

  // Fault pin drives low only in output mode with a live fault.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fault_oe_reg <= 1'b0;
      sda_out_reg <= 1'b0;
    end else begin
      fault_oe_reg <= sc2_reg[SC2_FAULT_OUT_BIT] && lvl[5];
      sda_out_reg <= 1'b0;
    end
  end

  assign sda_out = sda_out_reg;
  assign sda_oe = sda_oe_reg;
  assign fault_n_out = sda_out_reg;
  assign fault_n_oe = fault_oe_reg;
  assign dc_block_en = sc1_reg[SC1_DC_BLOCK_BIT];
  assign hard_unmute = sc1_reg[SC1_HARD_UNMUTE_BIT];
  assign deemph_sel = sc1_reg[1:0];
  assign serial_fmt = fmt_reg[3:0];
  assign shutdown = sc2_reg[SC2_SHUTDOWN_BIT];
  assign midz_ramp_en = sc2_reg[SC2_MIDZ_BIT];
  assign ternary_en = sc2_reg[SC2_TERNARY_BIT];
  assign audio_mute = audio_mute_reg;
  assign unmute_level = level_reg;

  ////////////////////////////////////////////////////////////////////////
  // Checks on the behaviour above.
  a_err_sticky: assert property (@(posedge clk) disable iff (!rst_n)
    !(wr_stb_reg && wr_idx_reg == REG_STICKY_ERROR_FLAGS) |=>
    (err_reg & $past(err_reg)) == $past(err_reg))
    else $error("sticky flag dropped without a write");
  a_set_wins: assert property (@(posedge clk) disable iff (!rst_n)
    ev_vec != 8'h00 |=> (err_reg & $past(ev_vec)) == $past(ev_vec))
    else $error("error event lost");
  a_mclk_flag: assert property (@(posedge clk) disable iff (!rst_n)
    ev_mclk |=> err_reg[ERR_MCLK_BIT])
    else $error("master clock change not flagged");
  a_sclk_flag: assert property (@(posedge clk) disable iff (!rst_n)
    ev_sclk |=> err_reg[ERR_SCLK_BIT] && clk_err_live_reg)
    else $error("bit clock change not flagged");
  a_ratio_64x: assert property (@(posedge clk) disable iff (!rst_n)
    clk_stat_reg[4:2] == MR_64 |-> clk_stat_reg[7:5] == FS_48K)
    else $error("64x reported outside 44.1/48 kHz");
  a_codes_legal: assert property (@(posedge clk) disable iff (!rst_n)
    clk_stat_reg[7:5] != 3'h1 && clk_stat_reg[7:5] != 3'h2 &&
    clk_stat_reg[4:2] < 3'h6 && clk_stat_reg[1:0] == 2'b00)
    else $error("reserved clock status code");
  a_ident_write: assert property (@(posedge clk) disable iff (!rst_n)
    wr_stb_reg && wr_idx_reg == REG_FIRMWARE_IDENT |=>
    $stable(sc1_reg) && $stable(fmt_reg) && $stable(sc2_reg))
    else $error("write to identification changed a setting");
  a_mute_clkerr: assert property (@(posedge clk) disable iff (!rst_n)
    clk_err_live_reg |=> audio_mute_reg ##1 level_reg == 12'h000)
    else $error("audio not muted on clock error");
  a_shutdown_mute: assert property (@(posedge clk) disable iff (!rst_n)
    sc2_reg[SC2_SHUTDOWN_BIT] |=> audio_mute_reg)
    else $error("shutdown without mute");
  a_hard_jump: assert property (@(posedge clk) disable iff (!rst_n)
    !audio_mute_reg && sc1_reg[SC1_HARD_UNMUTE_BIT] && level_reg != STEPS
    |=> level_reg == STEPS || audio_mute_reg)
    else $error("hard unmute took more than one step");
  a_soft_step: assert property (@(posedge clk) disable iff (!rst_n)
    !audio_mute_reg && !sc1_reg[SC1_HARD_UNMUTE_BIT] && level_reg != STEPS
    |=> level_reg == $past(level_reg) || level_reg == 12'h000 ||
        level_reg == $past(level_reg) + 12'h001)
    else $error("soft ramp skipped a step");
  a_fault_pin: assert property (@(posedge clk) disable iff (!rst_n)
    fault_oe_reg |-> $past(sc2_reg[SC2_FAULT_OUT_BIT]))
    else $error("fault pin driven in input mode");
endmodule
`default_nettype wire

// ---- design/aacsr_sync.sv ----
`timescale 1ns/10ps
`default_nettype none
module aacsr_sync #(
  parameter int W = 7,
  parameter logic [W-1:0] INIT = '0
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Raw inputs from outside the clock domain.
  input wire logic [W-1:0] async_in,
  // Synchronised level and edges.
  output logic [W-1:0] lvl,
  output logic [W-1:0] rise,
  output logic [W-1:0] fall
);
  logic [W-1:0] s1_reg;
  logic [W-1:0] s2_reg;
  logic [W-1:0] s3_reg;

  // Two stages against metastability, a third only for edge finding.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_reg <= INIT;
      s2_reg <= INIT;
      s3_reg <= INIT;
    end else begin
      s1_reg <= async_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  // Edges compare the settled stages only.
  assign lvl = s2_reg;
  assign rise = s2_reg & ~s3_reg;
  assign fall = ~s2_reg & s3_reg;
endmodule
`default_nettype wire

// ---- include/aacsr_pkg.sv ----
package aacsr_pkg;
  // Register subaddresses.
  localparam logic [7:0] REG_CLOCK_DETECT_STATUS = 8'h00;
  localparam logic [7:0] REG_FIRMWARE_IDENT = 8'h01;
  localparam logic [7:0] REG_STICKY_ERROR_FLAGS = 8'h02;
  localparam logic [7:0] REG_SYSTEM_CONTROL_FIRST = 8'h03;
  localparam logic [7:0] REG_SERIAL_AUDIO_FORMAT = 8'h04;
  localparam logic [7:0] REG_SYSTEM_CONTROL_SECOND = 8'h05;
  // Values after reset.
  localparam logic [7:0] RST_CLOCK_DETECT_STATUS = 8'h6C;
  localparam logic [7:0] RST_STICKY_ERROR_FLAGS = 8'h00;
  localparam logic [7:0] RST_SYSTEM_CONTROL_FIRST = 8'h80;
  localparam logic [7:0] RST_SERIAL_AUDIO_FORMAT = 8'h05;
  localparam logic [7:0] RST_SYSTEM_CONTROL_SECOND = 8'h40;
  // Field positions.
  localparam int SC1_DC_BLOCK_BIT = 7;
  localparam int SC1_HARD_UNMUTE_BIT = 5;
  localparam int SC2_MIDZ_BIT = 7;
  localparam int SC2_SHUTDOWN_BIT = 6;
  localparam int SC2_TERNARY_BIT = 3;
  localparam int SC2_FAULT_OUT_BIT = 1;
  localparam int ERR_MCLK_BIT = 7;
  localparam int ERR_PLL_BIT = 6;
  localparam int ERR_SCLK_BIT = 5;
  localparam int ERR_LRCLK_BIT = 4;
  localparam int ERR_SLIP_BIT = 3;
  localparam int ERR_CLIP_BIT = 2;
  localparam int ERR_PROT_BIT = 1;
  localparam logic [7:0] ERR_USED_MASK = 8'hFE;
  localparam logic [7:0] SC1_USED_MASK = 8'hA3;
  localparam logic [7:0] SC2_USED_MASK = 8'hCA;
  localparam logic [3:0] FMT_LAST_CODE = 4'h8;
  // Sample-rate and ratio status codes.
  localparam logic [2:0] FS_32K = 3'h0;
  localparam logic [2:0] FS_48K = 3'h3;
  localparam logic [2:0] FS_16K = 3'h4;
  localparam logic [2:0] FS_24K = 3'h5;
  localparam logic [2:0] FS_8K = 3'h6;
  localparam logic [2:0] FS_12K = 3'h7;
  localparam logic [2:0] MR_64 = 3'h0;
  localparam logic [2:0] MR_128 = 3'h1;
  localparam logic [2:0] MR_192 = 3'h2;
  localparam logic [2:0] MR_256 = 3'h3;
  localparam logic [2:0] MR_384 = 3'h4;
  localparam logic [2:0] MR_512 = 3'h5;
  // Timing, in the system clock.
  localparam int CLK_HZ = 25_000_000;
  localparam int CLK_PERIOD_NS = 40;
  localparam int FS_EDGE_40K_HZ = 40_000;
  localparam int FS_EDGE_28K_HZ = 28_000;
  localparam int FS_EDGE_20K_HZ = 20_000;
  localparam int FS_EDGE_14K_HZ = 14_000;
  localparam int FS_EDGE_10K_HZ = 10_000;
  localparam int THR_48K_CYC = CLK_HZ / FS_EDGE_40K_HZ;
  localparam int THR_32K_CYC = CLK_HZ / FS_EDGE_28K_HZ;
  localparam int THR_24K_CYC = CLK_HZ / FS_EDGE_20K_HZ;
  localparam int THR_16K_CYC = CLK_HZ / FS_EDGE_14K_HZ;
  localparam int THR_12K_CYC = CLK_HZ / FS_EDGE_10K_HZ;
  localparam int RAMP_STEP_NS = 83_300;
  localparam int RAMP_STEP_CYC = RAMP_STEP_NS / CLK_PERIOD_NS;
  localparam int RAMP_STEPS_DEFAULT = 512;
  localparam logic [11:0] PERIOD_MAX_CYC = 12'hFFF;
  localparam logic [11:0] MEAS_TOL = 12'h001;
  localparam logic [11:0] SLIP_TOL = 12'h002;
  localparam logic [6:0] BUS_ADDR_DEFAULT = 7'h2A;
  // Idle pin levels: control bus and fault pin high, the rest low.
  localparam logic [6:0] SYNC_INIT = 7'h43;
endpackage

// ---- testbench/aacsr_host.sv ----
`timescale 1ns/10ps
`default_nettype none
// Host model that bit-bangs the control bus, moving only after clk rises.
module aacsr_host
  import aacsr_pkg::*;
(
  // Clock and wire level.
  input wire logic clk,
  input wire logic sda,
  // Driven lines; sda_low pulls the open-drain wire down.
  output logic scl = 1'b1,
  output logic sda_low = 1'b0,
  // Bytes read, the newest in the low byte.
  output logic [47:0] got = '0
);
  ////////////////////////////////////////////////////////////////////////
  // Nine bits MSB first; data moves 4 clocks after SCL falls so that the
  // slave never mistakes it for a start or a stop.
  task automatic xbyte(input logic [8:0] d, output logic [8:0] q);
    for (int i = 8; i >= 0; i--) begin
      repeat (4) @(posedge clk);
      sda_low <= !d[i];
      repeat (8) @(posedge clk);
      scl <= 1'b1;
      repeat (8) @(posedge clk);
      q[i] = sda;
      scl <= 1'b0;
    end
  endtask
  // Start or repeated start when stop is low, stop when it is high.
  task automatic cond(input logic stop);
    repeat (4) @(posedge clk);
    sda_low <= stop;
    repeat (8) @(posedge clk);
    scl <= 1'b1;
    repeat (8) @(posedge clk);
    sda_low <= !stop;
    repeat (8) @(posedge clk);
    scl <= stop;
  endtask
  // Write d at sub when n is 0, else read n registers upwards from sub.
  task automatic xfer(input logic [7:0] sub, input logic [7:0] d,
                      input int n);
    logic [8:0] q;
    cond(1'b0);
    xbyte({BUS_ADDR_DEFAULT, 2'b01}, q);
    xbyte({sub, 1'b1}, q);
    if (n == 0) begin
      xbyte({d, 1'b1}, q);
    end else begin
      cond(1'b0);
      xbyte({BUS_ADDR_DEFAULT, 2'b11}, q);
      for (int i = 0; i < n; i++) begin
        xbyte({8'hFF, i == n - 1}, q);
        got = {got[39:0], q[8:1]};
      end
    end
    cond(1'b1);
  endtask
endmodule
`default_nettype wire

// ---- testbench/testbench.sv ----
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import aacsr_pkg::*;
  localparam int RS = 4;
  logic clk = 0, resetn = 0, run = 0, clip_event = 0, prot_fault = 0;
  logic mclk = 0, sclk = 0, lrclk = 0, scl, sda_low, sda_out, sda_oe;
  logic fault_n_out, fault_n_oe, dc_block_en, hard_unmute, shutdown;
  logic midz_ramp_en, ternary_en, audio_mute;
  logic [1:0] deemph_sel;
  logic [3:0] serial_fmt;
  logic [11:0] unmute_level;
  logic [47:0] got;
  logic [8:0] cnt = 0;
  int bad_count = 0, checks = 0;
  wire logic sda = !(sda_oe | sda_low);
  wire logic fault_n_in = !fault_n_oe;
  // Clocks; audio clocks stand still while run is low.
  always #20 clk = !clk;
  always @(posedge clk) begin
    cnt <= cnt + 9'(run);
    {lrclk, sclk, mclk} <= {cnt[8], cnt[2], cnt[1]};
  end
  aacsr_host aacsr_host_i (.clk, .sda, .scl, .sda_low, .got);
  // The identification value 8'h3C is arbitrary.
  aacsr_regs #(.FW_IDENT(8'h3C), .RAMP_STEPS(RS)) aacsr_regs_i (.clk,
    .resetn, .scl, .sda_in(sda), .sda_out, .sda_oe, .mclk, .sclk, .lrclk,
    .clip_event, .prot_fault, .fault_n_in, .fault_n_out, .fault_n_oe,
    .dc_block_en, .hard_unmute, .deemph_sel, .serial_fmt, .shutdown,
    .midz_ramp_en, .ternary_en, .audio_mute, .unmute_level);
  ////////////////////////////////////////////////////////////////////////
  // Compare, count and report.
  task automatic check(input string what, input logic [47:0] seen,
                       input logic [47:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic close_out();
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic xf(input logic [7:0] sub, input logic [7:0] d, input int n);
    aacsr_host_i.xfer(sub, d, n);
  endtask
  // Bounded wait at falling edges, where outputs have settled.
  task automatic wait_mute(input logic v);
    for (int i = 0; i < 9000; i++) begin
      @(negedge clk);
      if (audio_mute === v)
        return;
    end
    check("mute wait", 48'h1, 48'h0);
    close_out();
  endtask
  ////////////////////////////////////////////////////////////////////////
  // One burst, read before the frame-clock watchdog can trip.
  task automatic reset_values();
    xf(REG_CLOCK_DETECT_STATUS, 8'h00, 6);
    check("reset", got, {RST_CLOCK_DETECT_STATUS, 8'h3C, 8'h00,
      RST_SYSTEM_CONTROL_FIRST, 8'h05, RST_SYSTEM_CONTROL_SECOND});
  endtask
  // Every de-emphasis and format code, a reserved format, then ternary bring-up.
  task automatic control_fields();
    for (int d = 0; d < 4; d++) begin
      xf(REG_SYSTEM_CONTROL_FIRST, 8'(d), 0);
      check("sc1", 48'({dc_block_en, deemph_sel}), 48'(d));
    end
    for (int f = 0; f < 10; f++) begin
      xf(REG_SERIAL_AUDIO_FORMAT, 8'(f), 0);
      check("fmt", 48'(serial_fmt), 48'(f < 9 ? f : 8));
    end
    xf(REG_SYSTEM_CONTROL_FIRST, 8'hFF, 0);
    xf(REG_FIRMWARE_IDENT, 8'hFF, 0);
    xf(REG_SYSTEM_CONTROL_SECOND, 8'hCA, 0);
    for (int i = 0; i < 4; i++)
      xf(8'h11 + 8'(i), i[0] ? 8'h7C : 8'h80, 0);
    xf(REG_FIRMWARE_IDENT, 8'h00, 5);
    check("ctl", 48'({got[39:32], got[23:0]}), 48'h3CA3_08CA);
    check("out", 48'({ternary_en, midz_ramp_en, hard_unmute}), 48'h7);
    check("lvl", 48'({shutdown, dc_block_en, deemph_sel}), 48'hF);
  endtask
  // Clock status, sticky flags, mute and both unmute styles.
  task automatic audio_clocks();
    xf(REG_STICKY_ERROR_FLAGS, 8'h00, 1);
    check("idle", 48'(got[7:0]), 48'h10);
    run <= 1'b1;
    xf(REG_SYSTEM_CONTROL_SECOND, 8'h8A, 0);
    wait_mute(1'b0);
    repeat (2) @(negedge clk);
    check("hard", 48'(unmute_level), 48'(RS));
    xf(REG_STICKY_ERROR_FLAGS, 8'h00, 0);
    xf(REG_CLOCK_DETECT_STATUS, 8'h00, 3);
    check("stat", 48'({got[23:16], got[7:0]}), 48'h6400);
    clip_event <= 1'b1;
    prot_fault <= 1'b1;
    @(posedge clk);
    clip_event <= 1'b0;
    repeat (6) @(posedge clk);
    check("pin", 48'(fault_n_oe), 48'h1);
    prot_fault <= 1'b0;
    xf(REG_STICKY_ERROR_FLAGS, 8'h00, 1);
    check("events", 48'(got[7:0]), 48'h06);
    run <= 1'b0;
    wait_mute(1'b1);
    xf(REG_SYSTEM_CONTROL_FIRST, 8'h80, 0);
    run <= 1'b1;
    wait_mute(1'b0);
    check("soft0", 48'(unmute_level), 48'h0);
    repeat (RS * RAMP_STEP_CYC + 8) @(negedge clk);
    check("soft1", 48'(unmute_level), 48'(RS));
  endtask
  // Reset for 2 cycles, then the scenarios in turn.
  initial begin
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    repeat (6) @(posedge clk);
    reset_values();
    control_fields();
    audio_clocks();
    close_out();
  end
endmodule
`default_nettype wire
